// ==== hdl/chg_fault_queue.sv ====
`timescale 1ns/10ps
module chg_fault_queue #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  input wire logic pop,
  output logic [WIDTH-1:0] headData,
  output logic empty,
  output logic full
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("fault queue needs depth of two or more");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic [WIDTH-1:0] head;
    logic empty;
    logic full;
  } chg_queue_t;

  chg_queue_t r_r;
  chg_queue_t r_nxt;

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nextPtr

  always_comb begin
    logic doPush;
    logic doPop;
    doPush = push & ~r_r.full;
    doPop = pop & ~r_r.empty;
    r_nxt = r_r;
    if (doPush) begin
      r_nxt.mem[r_r.wrPtr] = pushData;
      r_nxt.wrPtr = nextPtr(r_r.wrPtr);
    end
    if (doPop) begin
      r_nxt.rdPtr = nextPtr(r_r.rdPtr);
    end
    r_nxt.count = r_r.count + CW'(doPush) - CW'(doPop);
    r_nxt.empty = (r_nxt.count == '0);
    r_nxt.full = (r_nxt.count == CW'(DEPTH));
    // head is registered from the next state so the reader sees it in the same cycle as empty and full
    r_nxt.head = r_nxt.empty ? '0 : r_nxt.mem[r_nxt.rdPtr];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_r <= '0;
      r_r.empty <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign headData = r_r.head;
  assign empty = r_r.empty;
  assign full = r_r.full;

endmodule : chg_fault_queue

// ==== hdl/chg_host_if.sv ====
// Function
// - slave only, same protocol at 100/400 kbps
// - 7-bit addressing, answers only 1101010
// - hang-up timer idles engine, ignores commands
// - timer restarts on start, stops on stop
// - detect start and stop while clock high
// - acknowledge matching address on ninth clock
// - direction bit picks sender; receiver acknowledges
// - bytes plus acknowledge repeat until stop
// - unlisted register offsets read back 0xff
// - host mode once write seen with power
// - stand-alone takes limit from select pins
// - watchdog expiry drops host mode, reloads defaults
// - status bit 7 is sticky watchdog flag
// - status bit 6 enables and restarts watchdog
// - bits 5:4 report charge state
// - bits 3:0 report fault code
// - queued faults read out one per read
// - regulator low with input undervoltage code
// - battery overvoltage stops converter, opens discharge
// - fifty second watchdog restarted by writes
`timescale 1ns/10ps
module chg_host_if #(
  parameter int unsigned WD_TIMEOUT_CYCLES = chg_pkg::WD_TIMEOUT_CYC,
  parameter int unsigned TXN_TIMEOUT_CYCLES = chg_pkg::TXN_TIMEOUT_CYC,
  parameter int FAULT_DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [chg_pkg::NUM_FAULT_PINS-1:0] faultIn,
  input wire logic ldoLow,
  input wire logic powerGood,
  input wire logic limitSelectPinA,
  input wire logic limitSelectPinB,
  input wire logic [1:0] chargePhase,
  output logic hostMode,
  output logic loadDefaults,
  output logic limitFromPins,
  output logic [1:0] limitPinCode,
  output logic converterOff,
  output logic batSwitchOn
);

  localparam int TXN_W = $clog2(TXN_TIMEOUT_CYCLES + 1);
  localparam int WD_W = $clog2(WD_TIMEOUT_CYCLES + 1);
  localparam int NF = chg_pkg::NUM_FAULTS;

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (TXN_TIMEOUT_CYCLES < 2 || WD_TIMEOUT_CYCLES < 2) begin : g_chk_time
    $error("timeout counts must be two or more");
  end
  if (chg_pkg::CLK_HZ / 1000 < chg_pkg::MIN_OVERSAMPLE * chg_pkg::FAST_RATE_KBPS)
  begin : g_chk_rate
    $error("system clock too slow for fast bus rate");
  end
  if (FAULT_DEPTH < 2) begin : g_chk_depth
    $error("fault queue depth must be two or more");
  end

  // --------------------------------------------------------------------------
  // link clock domain: one bit sample and an event toggle per rising edge
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic bitVal;
    logic tog;
  } chg_link_t;

  chg_link_t lk_r;
  chg_link_t lk_nxt;

  // sample stays stable for a whole clock low phase, so the toggle hands it over
  always_comb begin
    lk_nxt.bitVal = sdaIn;
    lk_nxt.tog = ~lk_r.tog;
  end

  always_ff @(posedge scl or posedge sys_rst) begin
    if (sys_rst) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // system clock domain state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic [1:0] togSync;
    logic sclD;
    logic sdaD;
    logic togD;
    logic [chg_pkg::EXT_W-1:0] ext1;
    logic [chg_pkg::EXT_W-1:0] ext2;
    chg_pkg::chg_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic firstData;
    logic [7:0] regSel;
    logic [7:0] txByte;
    logic fromQueue;
    logic sdaOe;
    logic sdaOut;
    logic txnActive;
    logic [TXN_W-1:0] txnCnt;
    logic wdEn;
    logic wdFlag;
    logic [WD_W-1:0] wdCnt;
    logic hostMode;
    logic loadDefaults;
    logic [NF:1] lvD;
    logic [NF:1] pending;
    logic uvloRecover;
    logic pushReq;
    logic [3:0] pushCode;
    logic popReq;
    logic limitFromPins;
    logic [1:0] limitPinCode;
    logic converterOff;
    logic batSwitchOn;
  } chg_host_regs_t;

  chg_host_regs_t r_r;
  chg_host_regs_t r_nxt;

  logic [3:0] qHead;
  logic qEmpty;
  logic qFull;

  // --------------------------------------------------------------------------
  // fault helpers
  // --------------------------------------------------------------------------
  function automatic logic [3:0] lowestCode(input logic [NF:1] v);
    lowestCode = chg_pkg::FLT_NORMAL;
    for (int i = NF; i >= 1; i--) begin
      if (v[i]) begin
        lowestCode = 4'(i);
      end
    end
  endfunction : lowestCode

  function automatic logic [NF:1] codeMask(input logic [3:0] code);
    codeMask = '0;
    for (int i = 1; i <= NF; i++) begin
      if (code == 4'(i)) begin
        codeMask[i] = 1'b1;
      end
    end
  endfunction : codeMask

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic startEvt;
    logic stopEvt;
    logic sclFall;
    logic bitEvt;
    logic addrHit;
    logic wdRestart;
    logic pgood;
    logic [NF:1] lv;
    logic [NF:1] rises;
    logic [1:0] stat;
    logic [3:0] faultShown;
    logic [7:0] readValue;
    logic [3:0] code;
    startEvt = 1'b0;
    stopEvt = 1'b0;
    sclFall = 1'b0;
    bitEvt = 1'b0;
    addrHit = 1'b0;
    wdRestart = 1'b0;
    pgood = 1'b0;
    lv = '0;
    rises = '0;
    stat = chg_pkg::CHG_READY;
    faultShown = chg_pkg::FLT_NORMAL;
    readValue = chg_pkg::UNMAPPED_VALUE;
    code = chg_pkg::FLT_NORMAL;

    r_nxt = r_r;
    r_nxt.loadDefaults = 1'b0;
    r_nxt.pushReq = 1'b0;
    r_nxt.popReq = 1'b0;
    r_nxt.sdaOut = 1'b0;

    // two-stage synchronisers; only the second stage is looked at
    r_nxt.sclSync = {r_r.sclSync[0], scl};
    r_nxt.sdaSync = {r_r.sdaSync[0], sdaIn};
    r_nxt.togSync = {r_r.togSync[0], lk_r.tog};
    r_nxt.sclD = r_r.sclSync[1];
    r_nxt.sdaD = r_r.sdaSync[1];
    r_nxt.togD = r_r.togSync[1];
    r_nxt.ext1 = {limitSelectPinB, limitSelectPinA, powerGood, ldoLow, faultIn};
    r_nxt.ext2 = r_r.ext1;

    // oversampled edges work the same at either rate
    startEvt = r_r.sclSync[1] & r_r.sclD & r_r.sdaD & ~r_r.sdaSync[1];
    stopEvt = r_r.sclSync[1] & r_r.sclD & ~r_r.sdaD & r_r.sdaSync[1];
    sclFall = r_r.sclD & ~r_r.sclSync[1];
    bitEvt = r_r.togSync[1] ^ r_r.togD;
    addrHit = (r_r.shift[7:1] == chg_pkg::SLAVE_ADDR);
    pgood = r_r.ext2[chg_pkg::EXT_PGOOD];

    // fault levels; the combined code covers undervoltage and its recovery
    lv[NF-1:1] = r_r.ext2[chg_pkg::NUM_FAULT_PINS-1:0];
    lv[NF] = r_r.ext2[chg_pkg::EXT_LDO] & (lv[chg_pkg::FLT_IN_UVLO] | r_r.uvloRecover);
    r_nxt.uvloRecover = lv[NF];
    stat = (|lv) ? chg_pkg::CHG_FAULT : chargePhase;
    faultShown = qEmpty ? lowestCode(lv) : qHead;
    if (r_r.regSel == chg_pkg::REG_STATUS) begin
      readValue = {r_r.wdFlag, r_r.wdEn, stat, faultShown};
    end else begin
      readValue = chg_pkg::UNMAPPED_VALUE;
    end

    // ------------------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------------------
    if (startEvt) begin
      r_nxt.txnActive = 1'b1;
      r_nxt.txnCnt = '0;
      r_nxt.state = chg_pkg::ST_ADDR;
      r_nxt.bitCnt = '0;
      r_nxt.sdaOe = 1'b0;
    end else if (stopEvt) begin
      r_nxt.txnActive = 1'b0;
      r_nxt.state = chg_pkg::ST_IDLE;
      r_nxt.sdaOe = 1'b0;
    end else if (r_r.txnActive && r_r.txnCnt == TXN_W'(TXN_TIMEOUT_CYCLES - 1)) begin
      // stuck transfer: drop the bus and wait for a fresh start
      r_nxt.txnActive = 1'b0;
      r_nxt.state = chg_pkg::ST_IDLE;
      r_nxt.sdaOe = 1'b0;
    end else begin
      if (r_r.txnActive) begin
        r_nxt.txnCnt = r_r.txnCnt + 1'b1;
      end
      if (bitEvt && r_r.state != chg_pkg::ST_IDLE) begin
        if (r_r.bitCnt != chg_pkg::BIT_ACK) begin
          r_nxt.shift = {r_r.shift[6:0], lk_r.bitVal};
          r_nxt.bitCnt = r_r.bitCnt + 1'b1;
        end else begin
          r_nxt.bitCnt = '0;
          unique case (r_r.state)
            chg_pkg::ST_ADDR: begin
              if (addrHit) begin
                r_nxt.state = r_r.shift[0] ? chg_pkg::ST_READ : chg_pkg::ST_WRITE;
                r_nxt.firstData = 1'b1;
              end else begin
                r_nxt.state = chg_pkg::ST_IDLE;
              end
            end
            chg_pkg::ST_WRITE: begin
              r_nxt.firstData = 1'b0;
              wdRestart = 1'b1;
              if (pgood) begin
                r_nxt.hostMode = 1'b1;
              end
              if (r_r.firstData) begin
                r_nxt.regSel = r_r.shift;
              end else if (r_r.regSel == chg_pkg::REG_STATUS) begin
                r_nxt.wdEn = r_r.shift[chg_pkg::WATCHDOG_ENABLE_BIT];
              end
            end
            chg_pkg::ST_READ: begin
              if (r_r.regSel == chg_pkg::REG_STATUS) begin
                r_nxt.popReq = r_r.fromQueue;
                r_nxt.wdFlag = 1'b0;
              end
              // master not acknowledging ends our sending
              if (lk_r.bitVal) begin
                r_nxt.state = chg_pkg::ST_IDLE;
              end
            end
            chg_pkg::ST_IDLE: begin
              r_nxt.state = chg_pkg::ST_IDLE;
            end
          endcase
        end
      end
      if (sclFall) begin
        unique case (r_r.state)
          chg_pkg::ST_ADDR: begin
            r_nxt.sdaOe = (r_r.bitCnt == chg_pkg::BIT_ACK) && addrHit;
          end
          chg_pkg::ST_WRITE: begin
            r_nxt.sdaOe = (r_r.bitCnt == chg_pkg::BIT_ACK);
          end
          chg_pkg::ST_READ: begin
            // loading at the first low phase lets a pop settle the queue head
            if (r_r.bitCnt == '0) begin
              r_nxt.txByte = {readValue[6:0], 1'b0};
              r_nxt.fromQueue = (r_r.regSel == chg_pkg::REG_STATUS) && !qEmpty;
              r_nxt.sdaOe = ~readValue[7];
            end else if (r_r.bitCnt == chg_pkg::BIT_ACK) begin
              r_nxt.sdaOe = 1'b0;
            end else begin
              r_nxt.sdaOe = ~r_r.txByte[7];
              r_nxt.txByte = {r_r.txByte[6:0], 1'b0};
            end
          end
          chg_pkg::ST_IDLE: begin
            r_nxt.sdaOe = 1'b0;
          end
        endcase
      end
    end

    // ------------------------------------------------------------------------
    // watchdog and mode handoff
    // ------------------------------------------------------------------------
    if (wdRestart || !r_nxt.wdEn) begin
      r_nxt.wdCnt = '0;
    end else if (r_r.wdCnt != WD_W'(WD_TIMEOUT_CYCLES)) begin
      r_nxt.wdCnt = r_r.wdCnt + 1'b1;
      if (r_r.wdCnt == WD_W'(WD_TIMEOUT_CYCLES - 1)) begin
        // set after the read clear so a same-cycle expiry is kept
        r_nxt.wdFlag = 1'b1;
        r_nxt.hostMode = 1'b0;
        r_nxt.loadDefaults = 1'b1;
      end
    end
    if (!pgood) begin
      r_nxt.hostMode = 1'b0;
    end
    r_nxt.limitFromPins = ~r_nxt.hostMode;
    r_nxt.limitPinCode = {r_r.ext2[chg_pkg::EXT_LIM_B], r_r.ext2[chg_pkg::EXT_LIM_A]};

    // ------------------------------------------------------------------------
    // fault capture: every new fault is queued once, lowest code first
    // ------------------------------------------------------------------------
    rises = lv & ~r_r.lvD;
    r_nxt.lvD = lv;
    r_nxt.pending = r_r.pending | rises;
    // alternate cycles so the registered full flag is never stale on a push
    if (r_r.pending != '0 && !qFull && !r_r.pushReq) begin
      code = lowestCode(r_r.pending);
      r_nxt.pushReq = 1'b1;
      r_nxt.pushCode = code;
      r_nxt.pending = (r_r.pending & ~codeMask(code)) | rises;
    end
    r_nxt.converterOff = lv[chg_pkg::FLT_BAT_OVP];
    r_nxt.batSwitchOn = lv[chg_pkg::FLT_BAT_OVP];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_r <= '0;
      r_r.state <= chg_pkg::ST_IDLE;
      r_r.wdEn <= chg_pkg::WATCHDOG_ENABLE_RESET;
      r_r.limitFromPins <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // fault queue
  // --------------------------------------------------------------------------
  chg_fault_queue #(
    .WIDTH(4),
    .DEPTH(FAULT_DEPTH)
  ) u_fault_queue (
    .clk(clk),
    .sys_rst(sys_rst),
    .push(r_r.pushReq),
    .pushData(r_r.pushCode),
    .pop(r_r.popReq),
    .headData(qHead),
    .empty(qEmpty),
    .full(qFull)
  );

  assign sdaOut = r_r.sdaOut;
  assign sdaOe = r_r.sdaOe;
  assign hostMode = r_r.hostMode;
  assign loadDefaults = r_r.loadDefaults;
  assign limitFromPins = r_r.limitFromPins;
  assign limitPinCode = r_r.limitPinCode;
  assign converterOff = r_r.converterOff;
  assign batSwitchOn = r_r.batSwitchOn;

endmodule : chg_host_if

// ==== hdl/chg_pkg.sv ====
package chg_pkg;

  // --------------------------------------------------------------------------
  // bus identity and rates
  // --------------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h6a;
  localparam int unsigned STD_RATE_KBPS = 100;
  localparam int unsigned FAST_RATE_KBPS = 400;
  // oversampling margin needed by the start/stop detector
  localparam int unsigned MIN_OVERSAMPLE = 20;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;
  localparam int unsigned WD_TIMEOUT_S = 50;
  localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_S * CLK_HZ;
  // hang-up timeout, far above a full multi-byte transfer at the slow rate
  localparam int unsigned TXN_TIMEOUT_US = 10_000;
  localparam int unsigned TXN_TIMEOUT_CYC = TXN_TIMEOUT_US * (CLK_HZ / HZ_PER_MHZ);

  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'hff;
  localparam int WD_FLAG_BIT = 7;
  localparam int WATCHDOG_ENABLE_BIT = 6;
  localparam logic WATCHDOG_ENABLE_RESET = 1'b0;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // --------------------------------------------------------------------------
  // charge state and fault codes
  // --------------------------------------------------------------------------
  localparam logic [1:0] CHG_READY = 2'h0;
  localparam logic [1:0] CHG_ACTIVE = 2'h1;
  localparam logic [1:0] CHG_DONE = 2'h2;
  localparam logic [1:0] CHG_FAULT = 2'h3;

  localparam int NUM_FAULTS = 10;
  localparam int NUM_FAULT_PINS = 9;
  localparam logic [3:0] FLT_NORMAL = 4'h0;
  localparam logic [3:0] FLT_IN_OVP = 4'h1;
  localparam logic [3:0] FLT_IN_UVLO = 4'h2;
  localparam logic [3:0] FLT_SLEEP = 4'h3;
  localparam logic [3:0] FLT_BAT_TEMP = 4'h4;
  localparam logic [3:0] FLT_BAT_OVP = 4'h5;
  localparam logic [3:0] FLT_THERMAL = 4'h6;
  localparam logic [3:0] FLT_TIMER = 4'h7;
  localparam logic [3:0] FLT_NO_BAT = 4'h8;
  localparam logic [3:0] FLT_RES_SHORT = 4'h9;
  localparam logic [3:0] FLT_IN_LDO_LOW = 4'ha;

  // --------------------------------------------------------------------------
  // synchronised side inputs, packed positions
  // --------------------------------------------------------------------------
  localparam int EXT_LDO = 9;
  localparam int EXT_PGOOD = 10;
  localparam int EXT_LIM_A = 11;
  localparam int EXT_LIM_B = 12;
  localparam int EXT_W = 13;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ADDR  = 4'h2,
    ST_WRITE = 4'h4,
    ST_READ  = 4'h8
  } chg_state_t;

endpackage : chg_pkg

// ==== test/chg_bus_master.sv ====
`timescale 1ns/10ps
module chg_bus_master (
  output logic scl,
  output logic sdaDrive,
  input wire logic sdaWire,
  output logic [8:0] result
);
  // ----
  // bus master model
  // ----
  // quarter bit; two quarters a phase leave the slave its 4-clock margin
  localparam time Q = 80;
  event done;
  initial begin
    scl = 1'b1;
    sdaDrive = 1'b0;
    result = 9'h000;
  end
  // data falls while clock high
  task automatic start();
    sdaDrive = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sdaDrive = 1'b1;
    #Q;
    scl = 1'b0;
    #Q;
  endtask : start
  // data rises while clock high, clock then stands still
  task automatic stop();
    sdaDrive = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sdaDrive = 1'b0;
    #Q;
  endtask : stop
  // msb first, data moves only with clock low, ninth slot acks
  task automatic xfer(input logic [8:0] bits);
    for (int i = 8; i >= 0; i--) begin
      sdaDrive = ~bits[i];
      #Q;
      scl = 1'b1;
      result[i] = sdaWire;
      #(2 * Q);
      scl = 1'b0;
      #Q;
    end
    ->done;
  endtask : xfer
endmodule : chg_bus_master

// ==== test/chg_host_if_assertions.sv ====
`timescale 1ns/10ps
module chg_host_if_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [chg_pkg::NUM_FAULT_PINS-1:0] faultIn,
  input wire logic powerGood,
  input wire logic limitSelectPinA,
  input wire logic limitSelectPinB,
  input wire logic hostMode,
  input wire logic loadDefaults,
  input wire logic limitFromPins,
  input wire logic [1:0] limitPinCode,
  input wire logic converterOff,
  input wire logic batSwitchOn
);
  // ----
  // checks
  // ----
  // pin of the battery overvoltage code
  localparam int OVP_BIT = 4;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  chk_sda_open_drain: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  chk_oe_scl_low: assert property ($changed(sdaOe) |-> !scl)
    else $error("data drive changed while clock high");
  chk_mode_pins: assert property (limitFromPins == !hostMode)
    else $error("limit source disagrees with mode");
  chk_bat_pair: assert property (batSwitchOn == converterOff)
    else $error("battery switch not paired with converter stop");
  chk_ovp_follow: assert property ($changed(faultIn[OVP_BIT]) |->
    ##[2:4] (converterOff == faultIn[OVP_BIT]))
    else $error("converter stop late");
  chk_pin_code: assert property (($stable({limitSelectPinB, limitSelectPinA}))[*5] |->
    limitPinCode == {limitSelectPinB, limitSelectPinA})
    else $error("pin code wrong");
  chk_defaults_pulse: assert property (loadDefaults |-> !hostMode ##1 !loadDefaults)
    else $error("defaults pulse wrong");
  chk_mode_power: assert property ((!powerGood)[*5] |-> !hostMode)
    else $error("host mode without power");
endmodule : chg_host_if_assertions

// ==== test/chg_host_if_tb.sv ====
`timescale 1ns/10ps
module chg_host_if_tb;
  // ----
  // setup
  // ----
  // short counts keep the run small
  localparam int unsigned WD_CYC = 3000;
  localparam int unsigned TXN_CYC = 1500;
  localparam logic [7:0] WR_ADDR = {chg_pkg::SLAVE_ADDR, 1'b0};
  localparam logic [7:0] RD_ADDR = {chg_pkg::SLAVE_ADDR, 1'b1};
  logic clk;
  logic sysRst;
  logic scl;
  logic sdaDrive;
  logic sdaWire;
  logic sdaOut;
  logic sdaOe;
  logic [8:0] faultIn;
  logic ldoLow;
  logic powerGood;
  logic pinA;
  logic pinB;
  logic [1:0] phase;
  logic hostMode;
  logic loadDefaults;
  logic limitFromPins;
  logic [1:0] limitPinCode;
  logic converterOff;
  logic batSwitchOn;
  logic [8:0] busResult;
  logic [31:0] seed;
  logic [8:0] expQ[$];
  int errors = 0;
  int samplesChecked = 0;
  int defaultsSeen = 0;
  // counts expiry pulses; negedge keeps clear of the launching edge
  always @(negedge clk) begin
    if (loadDefaults) defaultsSeen++;
  end
  // open drain with pull-up
  assign sdaWire = ~sdaDrive & (sdaOe ? sdaOut : 1'b1);
  chg_host_if #(.WD_TIMEOUT_CYCLES(WD_CYC), .TXN_TIMEOUT_CYCLES(TXN_CYC),
    .FAULT_DEPTH(4)) u_chg_host_if (
    .clk(clk), .sys_rst(sysRst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .faultIn(faultIn), .ldoLow(ldoLow), .powerGood(powerGood),
    .limitSelectPinA(pinA), .limitSelectPinB(pinB), .chargePhase(phase),
    .hostMode(hostMode), .loadDefaults(loadDefaults), .limitFromPins(limitFromPins),
    .limitPinCode(limitPinCode), .converterOff(converterOff), .batSwitchOn(batSwitchOn)
  );
  chg_bus_master u_bus_master (.scl(scl), .sdaDrive(sdaDrive), .sdaWire(sdaWire),
    .result(busResult));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] st(input logic f, input logic en, input logic [1:0] s,
    input logic [3:0] c);
    return {f, en, s, c};
  endfunction : st
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : look
  task automatic xb(input logic [7:0] d, input logic ackIn, input logic [8:0] exp);
    expQ.push_back(exp);
    u_bus_master.xfer({d, ackIn});
  endtask : xb
  task automatic head(input logic [7:0] off);
    u_bus_master.start();
    xb(WR_ADDR, 1'b1, {WR_ADDR, 1'b0});
    xb(off, 1'b1, {off, 1'b0});
  endtask : head
  task automatic wr(input logic [7:0] off, input logic [7:0] val);
    head(off);
    xb(val, 1'b1, {val, 1'b0});
    u_bus_master.stop();
  endtask : wr
  task automatic rd(input logic [7:0] off, input int n, input logic [15:0] e);
    head(off);
    u_bus_master.start();
    xb(RD_ADDR, 1'b1, {RD_ADDR, 1'b0});
    for (int k = 0; k < n; k++) begin
      xb(8'hff, k == n - 1, {e[15 - 8 * k -: 8], k == n - 1});
    end
    u_bus_master.stop();
  endtask : rd
  // ----
  // result watcher
  // ----
  initial begin
    forever begin
      @(u_bus_master.done);
      check("bus byte", busResult, expQ.pop_front());
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    conclude();
  end
  // ----
  // main sequence
  // ----
  initial begin
    sysRst = 1'b1;
    faultIn = 9'h000;
    ldoLow = 1'b0;
    powerGood = 1'b0;
    pinA = 1'b0;
    pinB = 1'b0;
    phase = 2'h0;
    seed = 32'h790ed2ff;
    repeat (10) @(posedge clk);
    sysRst <= 1'b0;
    look(1);
    check("reset mode", {8'h00, hostMode}, 9'h000);
    @(posedge clk);
    seed = lfsr(seed);
    pinA <= seed[0];
    pinB <= seed[1];
    phase <= (seed[3:2] == 2'h3) ? chg_pkg::CHG_ACTIVE : seed[3:2];
    look(6);
    check("pin code", {7'h00, limitPinCode}, {7'h00, pinB, pinA});
    $display("test reset and pins done");
    u_bus_master.start();
    xb(WR_ADDR ^ 8'h02, 1'b1, {WR_ADDR ^ 8'h02, 1'b1});
    xb(8'h00, 1'b1, {8'h00, 1'b1});
    u_bus_master.stop();
    $display("test foreign address done");
    wr(chg_pkg::REG_STATUS, 8'h40);
    look(6);
    check("mode unpowered", {8'h00, hostMode}, 9'h000);
    @(posedge clk);
    powerGood <= 1'b1;
    wr(chg_pkg::REG_STATUS, 8'h40);
    look(6);
    check("mode powered", {7'h00, hostMode, limitFromPins}, 9'h002);
    wr(chg_pkg::REG_STATUS, 8'h00);
    rd(chg_pkg::REG_STATUS, 2, {2{st(1'b0, 1'b0, phase, chg_pkg::FLT_NORMAL)}});
    wr(8'h05, 8'h3c);
    rd(8'h05, 1, {chg_pkg::UNMAPPED_VALUE, 8'h00});
    $display("test writes and reads done");
    @(posedge clk);
    faultIn <= 9'h050;
    look(8);
    check("ovp stop", {7'h00, converterOff, batSwitchOn}, 9'h003);
    rd(chg_pkg::REG_STATUS, 1, {st(1'b0, 1'b0, chg_pkg::CHG_FAULT, chg_pkg::FLT_BAT_OVP), 8'h00});
    @(posedge clk);
    faultIn <= 9'h000;
    look(8);
    rd(chg_pkg::REG_STATUS, 2, {st(1'b0, 1'b0, phase, chg_pkg::FLT_TIMER),
      st(1'b0, 1'b0, phase, chg_pkg::FLT_NORMAL)});
    @(posedge clk);
    faultIn <= 9'h001;
    look(8);
    rd(chg_pkg::REG_STATUS, 2, {2{st(1'b0, 1'b0, chg_pkg::CHG_FAULT, chg_pkg::FLT_IN_OVP)}});
    @(posedge clk);
    faultIn <= 9'h002;
    ldoLow <= 1'b1;
    look(8);
    @(posedge clk);
    faultIn <= 9'h000;
    look(8);
    // regulator still low while undervoltage recovers keeps the combined code
    rd(chg_pkg::REG_STATUS, 2, {st(1'b0, 1'b0, chg_pkg::CHG_FAULT, chg_pkg::FLT_IN_UVLO),
      st(1'b0, 1'b0, chg_pkg::CHG_FAULT, chg_pkg::FLT_IN_LDO_LOW)});
    @(posedge clk);
    ldoLow <= 1'b0;
    $display("test fault codes done");
    // the engine must have idled, so the late byte goes unanswered
    u_bus_master.start();
    xb(WR_ADDR, 1'b1, {WR_ADDR, 1'b0});
    look(TXN_CYC + 100);
    xb(8'h00, 1'b1, {8'h00, 1'b1});
    u_bus_master.stop();
    $display("test hang-up timer done");
    wr(chg_pkg::REG_STATUS, 8'h40);
    look(6);
    check("mode armed", {8'h00, hostMode}, 9'h001);
    check("defaults idle", 9'(defaultsSeen), 9'h000);
    look(WD_CYC + 50);
    check("mode expired", {7'h00, hostMode, limitFromPins}, 9'h001);
    check("defaults pulse", 9'(defaultsSeen), 9'h001);
    rd(chg_pkg::REG_STATUS, 1, {st(1'b1, 1'b1, phase, chg_pkg::FLT_NORMAL), 8'h00});
    rd(chg_pkg::REG_STATUS, 1, {st(1'b0, 1'b1, phase, chg_pkg::FLT_NORMAL), 8'h00});
    @(posedge clk);
    powerGood <= 1'b0;
    look(6);
    check("mode power loss", {8'h00, hostMode}, 9'h000);
    $display("test watchdog done");
    conclude();
  end
endmodule : chg_host_if_tb
bind chg_host_if chg_host_if_assertions u_chk (
  .clk(clk), .sys_rst(sys_rst), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .faultIn(faultIn), .powerGood(powerGood), .limitSelectPinA(limitSelectPinA),
  .limitSelectPinB(limitSelectPinB), .hostMode(hostMode), .loadDefaults(loadDefaults),
  .limitFromPins(limitFromPins), .limitPinCode(limitPinCode),
  .converterOff(converterOff), .batSwitchOn(batSwitchOn)
);
